// *** inc/wtw_regs.vh ***
// Timing and width constants for the wake timer watchdog
`ifndef WTW_REGS_VH
`define WTW_REGS_VH

// Clock and oscillator periods
`define WTW_REF_PERIOD_NS     10
`define WTW_NS_PER_MS         1000000
`define WTW_OSC_PERIOD_MS     10
`define WTW_TICK_CYCLES       (`WTW_OSC_PERIOD_MS * `WTW_NS_PER_MS / `WTW_REF_PERIOD_NS)

// Times in ms
`define WTW_WAKE_WIDTH_MS     20
`define WTW_RST_WIDTH_MS      320
`define WTW_CONV_TIME_MS      120
`define WTW_ACK_GUARD_MS      20
`define WTW_MR_QUALIFY_MS     20
`define WTW_MR_DEBOUNCE_MS    20

// Tick counts: widths round down, least times round up
`define WTW_WAKE_TICKS        (`WTW_WAKE_WIDTH_MS / `WTW_OSC_PERIOD_MS)
`define WTW_RST_TICKS         (`WTW_RST_WIDTH_MS / `WTW_OSC_PERIOD_MS)
`define WTW_CONV_TICKS        (`WTW_CONV_TIME_MS / `WTW_OSC_PERIOD_MS)
`define WTW_GUARD_TICKS       ((`WTW_ACK_GUARD_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)
`define WTW_QUAL_TICKS        ((`WTW_MR_QUALIFY_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)
`define WTW_DB_TICKS          ((`WTW_MR_DEBOUNCE_MS + `WTW_OSC_PERIOD_MS - 1) / `WTW_OSC_PERIOD_MS)

// Widths
`define WTW_PER_W             24
`define WTW_TCK_W             20
`define WTW_CNT_W             8
`define WTW_FLT_W             4

// State codes
`define WTW_ST_MEAS           2'h0
`define WTW_ST_RST            2'h1
`define WTW_ST_RUN            2'h2
`define WTW_ST_MRST           2'h3

`endif

// *** logic/wtw_mr_filter.v ***
// Manual reset qualifier and debouncer on the oscillator tick
`timescale 1ns/1ps
`default_nettype none
`include "wtw_regs.vh"

module wtw_mr_filter (
  input  wire ref_clk,
  input  wire nrst,
  input  wire tick,
  input  wire pin,
  output reg  mr_active_q
);

  localparam integer QUAL_I = `WTW_QUAL_TICKS;
  localparam integer DB_I   = `WTW_DB_TICKS;
  localparam [`WTW_FLT_W-1:0] QUAL = QUAL_I[`WTW_FLT_W-1:0];
  localparam [`WTW_FLT_W-1:0] DB   = DB_I[`WTW_FLT_W-1:0];

  reg [`WTW_FLT_W-1:0] hi_q;
  reg [`WTW_FLT_W-1:0] lo_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sampled only on ticks, so short glitches are never seen twice
  always @(posedge ref_clk) begin
    if (!nrst) begin
      hi_q        <= {`WTW_FLT_W{1'b0}};
      lo_q        <= {`WTW_FLT_W{1'b0}};
      mr_active_q <= 1'b0;
    end else if (tick) begin
      if (pin) begin
        lo_q <= {`WTW_FLT_W{1'b0}};
        if (hi_q != QUAL) begin
          hi_q <= hi_q + 4'h1;
        end
        if (hi_q == QUAL - 4'h1) begin
          mr_active_q <= 1'b1;
        end
      end else begin
        hi_q <= {`WTW_FLT_W{1'b0}};
        if (lo_q != DB) begin
          lo_q <= lo_q + 4'h1;
        end
        if (lo_q == DB - 4'h1) begin
          mr_active_q <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/wtw_core.v ***
// Wake timer with watchdog: interval, wake pulse, host reset, measurement
// Operation
// - Wake pulse at each interval start, not first interval nor after missed ack.
// - Wake output rests low when no pulse is issued.
// - Only a rising edge of the acknowledge counts.
// - Only the first acknowledge edge of an interval is acted upon.
// - Acknowledge clears watchdog state and ends any wake pulse; interval counter keeps running.
// - Acknowledge during a wake pulse ends the pulse at once.
// - No acknowledge 20 ms before interval end asserts host reset at start.
// - Host reset held low through power-on and resistor measurement.
// - Manual reset needs the pin high on two consecutive oscillator ticks.
// - Interval measured once after power-on and latched.
// - Missed ack or manual reset asserts reset and restarts counters.
// - Wake rising edges are spaced by the latched interval period.
// - Reset fall to next reset fall or wake equals period plus reset width.
// - Manual reset aborts measurement; measurement restarts after release.
// - Manual reset valid only if high 20 ms within 30 ms window.
// - Manual reset clears counters; resume after release plus debounce plus reset width.
// - Manual reset input is debounced against glitches.
// - Reset falls after qualify time, lasts request plus debounce plus width.
// - Manual reset forces wake low and host reset low.
// - Pin high at power-on is manual reset; no period latched.
`timescale 1ns/1ps
`default_nettype none
`include "wtw_regs.vh"

module wtw_core #(
  parameter [`WTW_TCK_W-1:0] TICK_CYCLES = `WTW_TICK_CYCLES
) (
  input  wire                  ref_clk,
  input  wire                  nrst,
  input  wire                  service_ack,
  input  wire                  interval_set_manual_reset_pin,
  input  wire                  meas_done,
  input  wire [`WTW_PER_W-1:0] meas_period,
  output reg                   meas_req_q,
  output reg                   interval_start_pulse_q,
  output reg                   host_reset_n_q
);

  localparam [1:0] ST_MEAS = `WTW_ST_MEAS;
  localparam [1:0] ST_RST  = `WTW_ST_RST;
  localparam [1:0] ST_RUN  = `WTW_ST_RUN;
  localparam [1:0] ST_MRST = `WTW_ST_MRST;

  localparam integer WAKE_I  = `WTW_WAKE_TICKS;
  localparam integer RST_I   = `WTW_RST_TICKS;
  localparam integer CONV_I  = `WTW_CONV_TICKS;
  localparam integer GUARD_I = `WTW_GUARD_TICKS;
  localparam [`WTW_CNT_W-1:0] WAKE_TICKS  = WAKE_I[`WTW_CNT_W-1:0];
  localparam [`WTW_CNT_W-1:0] RST_TICKS   = RST_I[`WTW_CNT_W-1:0];
  localparam [`WTW_CNT_W-1:0] CONV_TICKS  = CONV_I[`WTW_CNT_W-1:0];
  localparam [`WTW_PER_W-1:0] GUARD_TICKS = GUARD_I[`WTW_PER_W-1:0];

  reg  [`WTW_TCK_W-1:0] tick_cnt_q;
  reg                   tick_q;
  reg                   ack_prev_q;
  reg  [1:0]            state_q;
  reg  [`WTW_PER_W-1:0] per_q;
  reg                   per_valid_q;
  reg  [`WTW_PER_W-1:0] ivl_q;
  reg  [`WTW_CNT_W-1:0] cnt_q;
  reg  [`WTW_CNT_W-1:0] wake_cnt_q;
  reg                   acked_q;
  reg                   acked_d;
  wire                  mr_active;
  wire                  ack_rise;
  wire                  boundary;
  wire                  in_window;
  wire                  ack_take;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick from the reference clock
  always @(posedge ref_clk) begin
    if (!nrst) begin
      tick_cnt_q <= {`WTW_TCK_W{1'b0}};
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYCLES - 20'h1) begin
      tick_cnt_q <= {`WTW_TCK_W{1'b0}};
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 20'h1;
      tick_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Manual reset qualifier
  wtw_mr_filter u_mr (
    .ref_clk     (ref_clk),
    .nrst        (nrst),
    .tick        (tick_q),
    .pin         (interval_set_manual_reset_pin),
    .mr_active_q (mr_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge edge and watchdog state
  assign ack_rise  = service_ack & ~ack_prev_q;
  assign boundary  = (state_q == ST_RUN) && tick_q && (ivl_q == per_q - 24'h1);
  assign in_window = (state_q == ST_RST) ||
                     ((state_q == ST_RUN) && (ivl_q < per_q - GUARD_TICKS));
  assign ack_take  = ack_rise & ~acked_q & in_window;

  always @* begin
    if ((state_q != ST_RUN) && (state_q != ST_RST)) begin
      acked_d = 1'b0;
    end else if (boundary) begin
      acked_d = ack_rise; // Edge on the boundary belongs to the new interval
    end else begin
      acked_d = acked_q | ack_take;
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      ack_prev_q <= 1'b0;
      acked_q    <= 1'b0;
    end else begin
      ack_prev_q <= service_ack;
      acked_q    <= (mr_active) ? 1'b0 : acked_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_q                <= ST_MEAS;
      per_q                  <= {`WTW_PER_W{1'b0}};
      per_valid_q            <= 1'b0;
      ivl_q                  <= {`WTW_PER_W{1'b0}};
      cnt_q                  <= {`WTW_CNT_W{1'b0}};
      wake_cnt_q             <= {`WTW_CNT_W{1'b0}};
      meas_req_q             <= 1'b0;
      interval_start_pulse_q <= 1'b0;
      host_reset_n_q         <= 1'b0;
    end else begin
      case (state_q)
        ST_MEAS: begin
          host_reset_n_q         <= 1'b0;
          interval_start_pulse_q <= 1'b0;
          if (mr_active) begin
            meas_req_q <= 1'b0;
            state_q    <= ST_MRST;
          end else if (!meas_req_q) begin
            meas_req_q <= 1'b1;
            cnt_q      <= {`WTW_CNT_W{1'b0}};
          end else if (meas_done) begin
            per_q       <= meas_period;
            per_valid_q <= 1'b1;
            meas_req_q  <= 1'b0;
            cnt_q       <= {`WTW_CNT_W{1'b0}};
            state_q     <= ST_RST;
          end else if (tick_q) begin
            if (cnt_q == CONV_TICKS - 8'h1) begin
              meas_req_q <= 1'b0; // Overdue conversion is retried
            end else begin
              cnt_q <= cnt_q + 8'h1;
            end
          end
        end
        ST_RST: begin
          host_reset_n_q         <= 1'b0;
          interval_start_pulse_q <= 1'b0;
          ivl_q                  <= {`WTW_PER_W{1'b0}};
          if (mr_active) begin
            state_q <= ST_MRST;
          end else if (tick_q) begin
            if (cnt_q == RST_TICKS - 8'h1) begin
              cnt_q          <= {`WTW_CNT_W{1'b0}};
              host_reset_n_q <= 1'b1;
              state_q        <= ST_RUN;
            end else begin
              cnt_q <= cnt_q + 8'h1;
            end
          end
        end
        ST_RUN: begin
          if (mr_active) begin
            host_reset_n_q         <= 1'b0;
            interval_start_pulse_q <= 1'b0;
            ivl_q                  <= {`WTW_PER_W{1'b0}};
            state_q                <= ST_MRST;
          end else if (boundary) begin
            ivl_q <= {`WTW_PER_W{1'b0}};
            if (acked_q) begin
              interval_start_pulse_q <= 1'b1;
              wake_cnt_q             <= {`WTW_CNT_W{1'b0}};
            end else begin
              interval_start_pulse_q <= 1'b0;
              host_reset_n_q         <= 1'b0;
              cnt_q                  <= {`WTW_CNT_W{1'b0}};
              state_q                <= ST_RST;
            end
          end else begin
            if (tick_q) begin
              ivl_q <= ivl_q + 24'h1;
            end
            if (interval_start_pulse_q && ack_take) begin
              interval_start_pulse_q <= 1'b0;
            end else if (interval_start_pulse_q && tick_q) begin
              if (wake_cnt_q == WAKE_TICKS - 8'h1) begin
                interval_start_pulse_q <= 1'b0;
              end else begin
                wake_cnt_q <= wake_cnt_q + 8'h1;
              end
            end
          end
        end
        ST_MRST: begin
          host_reset_n_q         <= 1'b0;
          interval_start_pulse_q <= 1'b0;
          meas_req_q             <= 1'b0;
          ivl_q                  <= {`WTW_PER_W{1'b0}};
          cnt_q                  <= {`WTW_CNT_W{1'b0}};
          wake_cnt_q             <= {`WTW_CNT_W{1'b0}};
          if (!mr_active) begin
            state_q <= per_valid_q ? ST_RST : ST_MEAS;
          end
        end
        default: begin
          state_q                <= ST_MEAS;
          host_reset_n_q         <= 1'b0;
          interval_start_pulse_q <= 1'b0;
          meas_req_q             <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** test/wtw_core_assertions.sv ***
// Concurrent checks on the wake timer watchdog core ports
`timescale 1ns/1ps
`default_nettype none
`include "wtw_regs.vh"
module wtw_core_assertions #(
  parameter [`WTW_TCK_W-1:0] TICK_CYCLES = 20'h00004
) (
  input wire logic                  ref_clk,
  input wire logic                  nrst,
  input wire logic                  service_ack,
  input wire logic                  interval_set_manual_reset_pin,
  input wire logic                  meas_done,
  input wire logic [`WTW_PER_W-1:0] meas_period,
  input wire logic                  meas_req_q,
  input wire logic                  interval_start_pulse_q,
  input wire logic                  host_reset_n_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  localparam int T = TICK_CYCLES;
  localparam int R = `WTW_RST_TICKS;
  wire  wk  = interval_start_pulse_q;
  wire  rn  = host_reset_n_q;
  wire  pin = interval_set_manual_reset_pin;
  int   gap_q  = 0;
  int   hi_q   = 0;
  int   per_q  = 0;
  logic ev_q   = 1'b0;
  logic frst_q = 1'b0;
  logic bad_q  = 1'b0;
  logic got_q  = 1'b0;
  logic seen_q = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // Event spacing, pin high time, first ack in a pulse, latched period
  always @(posedge ref_clk) begin
    hi_q <= pin ? hi_q + 1 : 0;
    gap_q <= ($rose(wk) || $fell(rn)) ? 0 : gap_q + 1;
    ev_q <= nrst && (ev_q || $rose(wk) || $fell(rn));
    frst_q <= ($rose(wk) || $fell(rn)) ? $fell(rn) : frst_q;
    bad_q <= pin || (bad_q && !$rose(wk));
    seen_q <= wk && (seen_q || $rose(service_ack));
    got_q <= nrst && (got_q || (meas_req_q && meas_done));
    per_q <= (meas_req_q && meas_done && !got_q) ? int'(meas_period) : per_q;
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_wake_run; wk |-> rn; endproperty
  a_wake_run: assert property (p_wake_run) else $error("wake while reset low");
  property p_wake_width; $rose(wk) |-> ##20 !wk; endproperty
  a_wake_width: assert property (p_wake_width) else $error("wake stuck high");
  property p_ack_cut; wk && $rose(service_ack) && !seen_q |-> ##2 !wk; endproperty
  a_ack_cut: assert property (p_ack_cut) else $error("wake not cut by ack");
  property p_spacing; $rose(wk) && ev_q && !frst_q && !bad_q |-> gap_q + 1 == per_q * T; endproperty
  a_spacing: assert property (p_spacing) else $error("wake spacing wrong");
  property p_rst_wake;
    $rose(wk) && ev_q && frst_q && !bad_q
      |-> gap_q + 2 >= (R + per_q) * T && gap_q <= (R + 1 + per_q) * T;
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset to wake time wrong");
  property p_meas_rst; meas_req_q |-> !rn; endproperty
  a_meas_rst: assert property (p_meas_rst) else $error("reset high in measure");
  property p_once; got_q |=> !meas_req_q; endproperty
  a_once: assert property (p_once) else $error("second measurement");
  property p_mr_hold; hi_q > 3 * T |-> !rn && !wk; endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("manual reset not acting");
  property p_mr_rel; $fell(pin) && !rn |-> ##100 !rn; endproperty
  a_mr_rel: assert property (p_mr_rel) else $error("reset ended early");
endmodule
bind wtw_core wtw_core_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .ref_clk(ref_clk), .nrst(nrst), .service_ack(service_ack),
  .interval_set_manual_reset_pin(interval_set_manual_reset_pin),
  .meas_done(meas_done), .meas_period(meas_period), .meas_req_q(meas_req_q),
  .interval_start_pulse_q(interval_start_pulse_q), .host_reset_n_q(host_reset_n_q));
`default_nettype wire

// *** test/wtw_host_model.sv ***
// Host model answering wake and reset release with an acknowledge pulse
`timescale 1ns/1ps
`default_nettype none
module wtw_host_model (
  input  wire logic       ref_clk,
  input  wire logic       wake,
  input  wire logic       rst_n,
  input  wire logic [7:0] ack_dly,
  output var  logic       ack
);
  logic       wake_q = 1'b0;
  logic       rst_q  = 1'b0;
  logic [7:0] cnt_q  = 8'h00;
  logic [3:0] hold_q = 4'h0;
  always @(posedge ref_clk) begin
    wake_q <= wake;
    rst_q <= rst_n;
    if ((wake && !wake_q) || (rst_n && !rst_q))
      cnt_q <= ack_dly;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
    if (cnt_q == 8'h01)
      hold_q <= 4'hA;
    else if (hold_q != 4'h0)
      hold_q <= hold_q - 4'h1;
  end
  assign ack = (hold_q != 4'h0);
endmodule
`default_nettype wire

// *** test/wtw_core_bench.sv ***
// Self-checking bench for the wake timer watchdog core
`timescale 1ns/1ps
`default_nettype none
`define WTW_CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin failures++; \
  $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end
`define WTW_WAIT(c, lim) n = 0; while (!(c) && n < (lim)) begin step(); n++; end
module wtw_core_bench;
  localparam int T = 8;
  logic        ref_clk;
  logic        nrst;
  logic        pin;
  logic        done;
  logic [23:0] per;
  logic [7:0]  dly;
  logic        ack;
  logic        req;
  logic        wk;
  logic        rn;
  int          failures;
  int          check_count;
  int          cyc;
  wtw_core #(.TICK_CYCLES(20'h00008)) dut (.ref_clk(ref_clk), .nrst(nrst), .service_ack(ack),
    .interval_set_manual_reset_pin(pin), .meas_done(done), .meas_period(per),
    .meas_req_q(req), .interval_start_pulse_q(wk), .host_reset_n_q(rn));
  wtw_host_model host (.ref_clk(ref_clk), .wake(wk), .rst_n(rn), .ack_dly(dly), .ack(ack));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_meas();
    int n;
    repeat (40) step();
    `WTW_CHK("req pin high", 1'b0, req)
    `WTW_CHK("reset pin high", 1'b0, rn)
    pin = 1'b0;
    `WTW_WAIT(req, 100)
    `WTW_CHK("req released", 1'b1, req)
    step();
    done = 1'b1;
    per = 24'h000008;
    step();
    done = 1'b0;
    step();
    `WTW_CHK("req after done", 1'b0, req)
    `WTW_WAIT(rn, 400)
    `WTW_CHK("reset phase", 1'b1, rn && n >= 31 * T && n <= 34 * T)
  endtask
  task automatic t_run();
    int n;
    int w;
    `WTW_WAIT(wk, 200)
    `WTW_CHK("first wake", 1'b1, wk && n >= 7 * T)
    `WTW_WAIT(!wk, 40)
    w = n;
    `WTW_WAIT(wk, 200)
    `WTW_CHK("wake width", 1'b1, w > 0 && w < 2 * T)
    `WTW_CHK("wake spacing", 8 * T, n + w)
  endtask
  task automatic t_miss();
    int n;
    `WTW_WAIT(!wk, 40)
    dly = 8'h3C;
    `WTW_WAIT(wk, 200)
    `WTW_WAIT(!rn, 200)
    `WTW_CHK("late ack reset", 1'b1, !rn && n >= 8 * T - 2 && n <= 8 * T + 1)
    `WTW_CHK("no wake on miss", 1'b0, wk)
    dly = 8'h0A;
    `WTW_WAIT(rn, 400)
    `WTW_CHK("reset width", 1'b1, rn && n >= 32 * T - 1 && n <= 33 * T)
    `WTW_WAIT(wk, 200)
    `WTW_CHK("wake after reset", 1'b1, wk && n >= 7 * T)
  endtask
  task automatic t_mr();
    int n;
    `WTW_WAIT(!wk, 40)
    pin = 1'b1;
    repeat (5) step();
    pin = 1'b0;
    `WTW_WAIT(!rn, 40)
    `WTW_CHK("glitch", 1'b1, rn)
    pin = 1'b1;
    `WTW_WAIT(!rn, 40)
    `WTW_CHK("manual delay", 1'b1, !rn && n >= T && n <= 2 * T + 1)
    `WTW_CHK("manual wake", 1'b0, wk)
    repeat (30) step();
    pin = 1'b0;
    `WTW_WAIT(rn, 400)
    `WTW_CHK("manual end", 1'b1, rn && n >= 33 * T && n <= 35 * T + 1)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    pin = 1'b1;
    done = 1'b0;
    per = 24'h000000;
    dly = 8'h0A;
    failures = 0;
    check_count = 0;
    cyc = 0;
    repeat (5) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    t_meas();
    t_run();
    t_miss();
    t_mr();
    end_sim();
  end
endmodule
`default_nettype wire
